/* sim/tal_properties.sv */
// Purpose: link framing and alert checks beside the host-sensor link
// Assumes: sclk half period of four mclk cycles
// Notes: the alert checks expect no register reads while comparator mode is on
`timescale 1ns/1ps
module tal_properties
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic temp_valid_i,
  input wire logic alert_o,
  input wire logic shutdown_o,
  input wire logic rd_done_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////
  property p_rd_clear;
    rd_done_o && !temp_valid_i |=> !alert_o;
  endproperty
  property p_rise;
    $rose(alert_o) |-> $past(temp_valid_i) || $past(temp_valid_i, 2);
  endproperty
  property p_sd_clear;
    $rose(shutdown_o) |-> ##[0:1] !alert_o;
  endproperty
  property p_sd_hold;
    shutdown_o && $past(shutdown_o) |-> !$rose(alert_o);
  endproperty
  property p_miso;
    !cs_n && $changed(miso) |-> !sclk;
  endproperty
  property p_mosi;
    !cs_n && sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  property p_low;
    $fell(sclk) |-> !sclk [*4] ##1 sclk;
  endproperty
  property p_idle;
    cs_n |-> sclk;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("alert held after read");
  a_rise: assert property (p_rise) else $error("alert rose without sample");
  a_sd_clear: assert property (p_sd_clear) else $error("alert held in shutdown");
  a_sd_hold: assert property (p_sd_hold) else $error("alert rose in shutdown");
  a_miso: assert property (p_miso) else $error("miso moved with sclk high");
  a_mosi: assert property (p_mosi) else $error("mosi moved with sclk high");
  a_low: assert property (p_low) else $error("sclk low phase length");
  a_idle: assert property (p_idle) else $error("sclk low outside frame");
  c_alert: cover property ($rose(alert_o));
  c_read: cover property (rd_done_o);
  c_sd: cover property ($rose(shutdown_o));
endmodule

/* sim/temp_alert_latch_and_bringup_test.sv */
// Purpose: drives both link ends through apb and the converter port
// Assumes: short serial reset wait so the run stays brief
// Notes: expected alert is tracked as a sticky flag cleared by reads
`timescale 1ns/1ps
module temp_alert_latch_and_bringup_test
  import tal_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_o, alert_o, shutdown_o, rd_done_o;
  logic [15:0] temp_i = 16'h0;
  logic temp_valid_i = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 81185;
  logic [31:0] q, r;
  logic e, exp_al;
  logic [2:0] mk;
  logic [15:0] up, lo, t;
  logic [2:0] ra [6] = '{A_CONFIG, A_IDENT, A_CRIT, A_HYST, A_UPPER, A_LOWER};
  logic [15:0] rv [6] = '{{8'h00, CONFIG_DEF}, {8'h00, IDENT_VAL}, CRIT_DEF, {12'h0, HYST_DEF}, UPPER_DEF, LOWER_DEF};
  tal_link_if tal_link_if_inst ();
  tal_dev tal_dev_inst (.mclk_i(mclk_i), .reset_i(reset_i), .link(tal_link_if_inst), .temp_i(temp_i),
    .temp_valid_i(temp_valid_i), .alert_o(alert_o), .shutdown_o(shutdown_o), .rd_done_o(rd_done_o));
  tal_host #(.RST_WAIT(20)) tal_host_inst (.mclk_i(mclk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_o(irq_o), .link(tal_link_if_inst));
  tal_properties tal_properties_inst (.mclk_i(mclk_i), .reset_i(reset_i), .sclk(tal_link_if_inst.sclk),
    .cs_n(tal_link_if_inst.cs_n), .mosi(tal_link_if_inst.mosi), .miso(tal_link_if_inst.miso),
    .temp_valid_i(temp_valid_i), .alert_o(alert_o), .shutdown_o(shutdown_o), .rd_done_o(rd_done_o));
  initial
    forever #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_of_test();
    end
  endtask
  // poll, check the interrupt line against the mask, then clear all
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, H_IRQ_STAT, 32'h0);
      n++;
    end
    while (q[b] !== 1'b1 && n < 3000);
    if (q[b] !== 1'b1)
    begin
      num_errors++;
      end_of_test();
    end
    chk("irq level", {31'h0, irq_o}, {31'h0, mk[b]});
    apb(1'b1, H_IRQ_STAT, 32'h7);
    repeat (2) @(posedge mclk_i);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
  endtask
  task automatic xfer(input logic rd, input logic [2:0] a, input logic [15:0] d);
    apb(1'b1, H_WDATA, {16'h0, d});
    apb(1'b1, H_CMD, {28'h0, rd, a});
    wait_irq(IRQ_DONE);
    apb(1'b0, H_RDATA, 32'h0);
  endtask
  task automatic sample(input logic [15:0] v);
    @(posedge mclk_i);
    temp_i <= v;
    temp_valid_i <= 1'b1;
    @(posedge mclk_i);
    temp_valid_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic bringup();
    apb(1'b1, H_WDATA, 32'h0);
    apb(1'b1, H_CMD, 32'h10);
    wait_irq(IRQ_PASS);
    apb(1'b0, H_STATUS, 32'h0);
    chk("link status", q, 32'h2);
  endtask
  function automatic logic out_win(input logic [15:0] v, input logic [15:0] u, input logic [15:0] l);
    return $signed(v) > $signed(u) || $signed(v) < $signed(l);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    apb(1'b0, H_STATUS, 32'h0);
    chk("status reset", q, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    mk = 3'h7;
    apb(1'b1, H_IRQ_MASK, {29'h0, mk});
    bringup();
    foreach (ra[i])
    begin
      xfer(1'b1, ra[i], 16'h0);
      chk("default", q, {16'h0, rv[i]});
    end
    r = $random(seed);
    up = 16'h1000 + {4'h0, r[11:0]};
    lo = ~up;
    xfer(1'b0, A_UPPER, up);
    xfer(1'b0, A_LOWER, lo);
    xfer(1'b1, A_LOWER, 16'h0);
    chk("lower", q, {16'h0, lo});
    exp_al = 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      r = $random(seed);
      t = (i == 0) ? up : (i == 1) ? up + 16'h1 : (i == 2) ? lo : (i == 3) ? lo - 16'h1 : r[15:0];
      sample(t);
      exp_al = exp_al | out_win(t, up, lo);
      chk("alert", {31'h0, alert_o}, {31'h0, exp_al});
      if (i == 15)
      begin
        mk = 3'h0;
        apb(1'b1, H_IRQ_MASK, 32'h0);
      end
      if (i % 5 == 4)
      begin
        xfer(1'b1, A_TEMP, 16'h0);
        chk("temp", q, {16'h0, t});
        exp_al = 1'b0;
        chk("alert read", {31'h0, alert_o}, 32'h0);
      end
    end
    // comparator mode: no reads here, an in-window sample must release
    xfer(1'b0, A_CONFIG, 16'h1 << CFG_CMP_BIT);
    sample(up + 16'h1);
    chk("alert cmp", {31'h0, alert_o}, 32'h1);
    sample(16'h0000);
    chk("alert cmp release", {31'h0, alert_o}, 32'h0);
    xfer(1'b0, A_CONFIG, 16'h0);
    sample(up + 16'h1);
    chk("alert set", {31'h0, alert_o}, 32'h1);
    xfer(1'b0, A_CONFIG, {9'h0, CFG_SD_VAL, 5'h0});
    chk("shutdown", {31'h0, shutdown_o}, 32'h1);
    chk("alert sd", {31'h0, alert_o}, 32'h0);
    sample(up + 16'h1);
    chk("alert sd sample", {31'h0, alert_o}, 32'h0);
    xfer(1'b0, A_CONFIG, 16'h0);
    chk("wake", {31'h0, shutdown_o}, 32'h0);
    mk = 3'h7;
    apb(1'b1, H_IRQ_MASK, 32'h7);
    bringup();
    xfer(1'b1, A_UPPER, 16'h0);
    chk("upper restored", q, {16'h0, UPPER_DEF});
    end_of_test();
  end
endmodule

/* verilog/tal_dev.sv */
// What this block does
// - latched mode: any completed read clears alert
// - after clear, re-assert only on out-of-window sample
// - latched mode: entering shutdown clears alert
// - host sends thirty-two ones after power-up
// - identification register returns fixed code
// - host repeats identification read until results agree
// - limits and configuration read back defaults
// - host accepts link only if defaults match
// - after configuration, temperature read returns sample
// - alert when sample above upper or below lower
// - comparator mode releases alert using hysteresis
// - command byte: 0, read bit, address, 000
// - thirty-two ones reset interface and registers
// Purpose: sensor end of the serial link with alert logic
// Assumes: link pins are asynchronous to mclk_i, sampled by two flops
// Notes: temperature samples arrive on temp_valid_i from the converter
`timescale 1ns/1ps
module tal_dev
  import tal_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  tal_link_if.dev link,
  input wire logic [15:0] temp_i,
  input wire logic temp_valid_i,
  output logic alert_o,
  output logic shutdown_o,
  output logic rd_done_o
);

  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_JUNK} tal_ph_t;

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic din_m;
    logic din_s;
    tal_ph_t ph;
    logic [4:0] cnt;
    logic [5:0] ones;
    logic rw;
    logic [2:0] addr;
    logic [15:0] sh;
    logic [15:0] tx;
    logic dout;
    logic [7:0] cfg;
    logic [15:0] temp;
    logic [15:0] crit;
    logic [3:0] hyst;
    logic [15:0] upper;
    logic [15:0] lower;
    logic alert;
    logic sd_d;
    logic rd_done;
  } tal_dev_st_t;

  tal_dev_st_t s_r;
  tal_dev_st_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rd_val(input tal_dev_st_t s, input logic [2:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      A_CONFIG: v = {s.cfg, 8'h00};
      A_TEMP: v = s.temp;
      A_IDENT: v = {IDENT_VAL, 8'h00};
      A_CRIT: v = s.crit;
      A_HYST: v = {4'h0, s.hyst, 8'h00};
      A_UPPER: v = s.upper;
      A_LOWER: v = s.lower;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic rise;
  logic fall;
  logic din;
  logic [7:0] cmd;
  logic [15:0] word;
  logic [4:0] last;
  logic sd;
  logic over;
  logic under;
  logic [15:0] hyst_w;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rd_done = 1'b0;
    s_nxt.sclk_m = link.sclk;
    s_nxt.sclk_s = s_r.sclk_m;
    s_nxt.sclk_d = s_r.sclk_s;
    s_nxt.cs_m = link.cs_n;
    s_nxt.cs_s = s_r.cs_m;
    s_nxt.din_m = link.mosi;
    s_nxt.din_s = s_r.din_m;
    rise = s_r.sclk_s & ~s_r.sclk_d;
    fall = ~s_r.sclk_s & s_r.sclk_d;
    din = s_r.din_s;
    word = {s_r.sh[14:0], din};
    cmd = word[7:0];
    last = reg_is16(s_r.addr) ? 5'h0f : 5'h07;

    if (s_r.cs_s)
    begin
      s_nxt.ph = PH_CMD;
      s_nxt.cnt = 5'h00;
    end
    else if (rise)
    begin
      s_nxt.sh = word;
      s_nxt.cnt = s_r.cnt + 5'h01;
      case (s_r.ph)
        PH_CMD:
        begin
          if (s_r.cnt == 5'h07)
          begin
            s_nxt.cnt = 5'h00;
            if (cmd[7] || (cmd[2:0] != 3'h0))
            begin
              s_nxt.ph = PH_JUNK;
            end
            else
            begin
              s_nxt.ph = PH_DATA;
              s_nxt.rw = cmd[CMD_RD_BIT];
              s_nxt.addr = cmd[CMD_ADDR_LSB +: 3];
              s_nxt.tx = rd_val(s_r, cmd[CMD_ADDR_LSB +: 3]);
            end
          end
        end
        PH_DATA:
        begin
          if (s_r.cnt == last)
          begin
            // one register per frame; later clocks are ignored
            s_nxt.ph = PH_JUNK;
            if (s_r.rw)
            begin
              s_nxt.rd_done = 1'b1;
            end
            else
            begin
              case (s_r.addr)
                A_CONFIG: s_nxt.cfg = word[7:0];
                A_CRIT: s_nxt.crit = word;
                A_HYST: s_nxt.hyst = word[3:0];
                A_UPPER: s_nxt.upper = word;
                A_LOWER: s_nxt.lower = word;
                default: s_nxt.cfg = s_r.cfg;
              endcase
            end
          end
        end
        default: s_nxt.ph = PH_JUNK;
      endcase
    end

    if (!s_r.cs_s && fall && s_r.ph == PH_DATA && s_r.rw)
    begin
      s_nxt.dout = s_r.tx[15];
      s_nxt.tx = {s_r.tx[14:0], 1'b0};
    end

    // ones are counted across frame and byte borders
    if (rise)
    begin
      s_nxt.ones = din ? ((s_r.ones == 6'(ONES_RST)) ? s_r.ones : s_r.ones + 6'h01) : 6'h00;
    end

    // alert handling
    sd = (s_r.cfg[CFG_SD_LSB +: 2] == CFG_SD_VAL);
    s_nxt.sd_d = sd;
    hyst_w = 16'({s_r.hyst, 7'h00});
    over = $signed(temp_i) > $signed(s_r.upper);
    under = $signed(temp_i) < $signed(s_r.lower);
    if (!s_r.cfg[CFG_CMP_BIT])
    begin
      if (s_nxt.rd_done)
      begin
        s_nxt.alert = 1'b0;
      end
      if (sd && !s_r.sd_d)
      begin
        s_nxt.alert = 1'b0;
      end
    end
    // an out-of-window sample wins over a read clear in the same cycle
    if (temp_valid_i && !sd)
    begin
      s_nxt.temp = temp_i;
      if (over || under)
      begin
        s_nxt.alert = 1'b1;
      end
      else if (s_r.cfg[CFG_CMP_BIT] &&
               (($signed(temp_i) < $signed(s_r.upper - hyst_w)) ||
                ($signed(temp_i) > $signed(s_r.lower + hyst_w))))
      begin
        s_nxt.alert = 1'b0;
      end
    end

    if (rise && din && s_r.ones == 6'(ONES_RST - 1))
    begin
      s_nxt.ph = PH_JUNK;
      s_nxt.cfg = CONFIG_DEF;
      s_nxt.temp = 16'h0000;
      s_nxt.crit = CRIT_DEF;
      s_nxt.hyst = HYST_DEF;
      s_nxt.upper = UPPER_DEF;
      s_nxt.lower = LOWER_DEF;
      s_nxt.alert = 1'b0;
      // miso kept: it may only move while sclk is low
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_r <= '0;
      s_r.sclk_m <= 1'b1;
      s_r.sclk_s <= 1'b1;
      s_r.sclk_d <= 1'b1;
      s_r.cs_m <= 1'b1;
      s_r.cs_s <= 1'b1;
      s_r.ph <= PH_CMD;
      s_r.cfg <= CONFIG_DEF;
      s_r.crit <= CRIT_DEF;
      s_r.hyst <= HYST_DEF;
      s_r.upper <= UPPER_DEF;
      s_r.lower <= LOWER_DEF;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign link.miso = s_r.dout;
  assign alert_o = s_r.alert;
  assign shutdown_o = s_r.sd_d;
  assign rd_done_o = s_r.rd_done;

endmodule

/* verilog/tal_host.sv */
// Purpose: serial master with bring-up sequencer, controlled over apb
// Assumes: miso is asynchronous to mclk_i, sampled by two flops
// Notes: sclk derived from mclk_i by a divider, idles high
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module tal_host
  import tal_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC,
  parameter int RST_WAIT = RST_WAIT_CYC
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_o,
  tal_link_if.host link
);

  typedef enum logic [2:0] {Q_IDLE, Q_RST, Q_PAUSE, Q_ID, Q_DEF, Q_WCFG, Q_TEMP, Q_ONE} tal_q_t;
  typedef enum logic [1:0] {E_IDLE, E_LO, E_HI, E_GAP} tal_e_t;

  typedef struct packed {
    tal_q_t q;
    tal_e_t e;
    logic pend;
    logic [15:0] div;
    logic [5:0] bitn;
    logic [5:0] nb;
    logic [31:0] tx;
    logic [15:0] rx;
    logic sclk;
    logic csn;
    logic mosi;
    logic miso_m;
    logic miso_s;
    logic [2:0] addr;
    logic rd;
    logic [1:0] idx;
    logic have_prev;
    logic [7:0] prev;
    logic ok;
    logic link_ok;
    logic link_fail;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [2:0] ist;
    logic [2:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tal_host_st_t;

  tal_host_st_t s_r;
  tal_host_st_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] def_addr(input logic [1:0] i);
    case (i)
      2'h0: return A_CONFIG;
      2'h1: return A_CRIT;
      2'h2: return A_UPPER;
      default: return A_LOWER;
    endcase
  endfunction

  function automatic logic [31:0] rd_frame(input logic [2:0] a);
    return {cmd_byte(1'b1, a), 24'h000000};
  endfunction

  function automatic logic [5:0] frame_len(input logic [2:0] a);
    return reg_is16(a) ? 6'd24 : 6'd16;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic go;
  logic [31:0] gtx;
  logic [5:0] gnb;
  logic done;
  logic [15:0] rxv;
  logic acc;
  logic [2:0] iset;
  logic [2:0] a;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.miso_m = link.miso;
    s_nxt.miso_s = s_r.miso_m;
    go = 1'b0;
    gtx = rd_frame(A_IDENT);
    gnb = 6'd16;
    iset = 3'h0;
    done = (s_r.e == E_GAP) && (s_r.div == 16'(2 * SCLK_HALF - 1));
    rxv = s_r.rx;
    a = def_addr(s_r.idx);

    case (s_r.q)
      Q_RST:
      begin
        go = 1'b1;
        gtx = 32'hffffffff;
        gnb = 6'(ONES_RST);
        if (done)
        begin
          s_nxt.q = Q_PAUSE;
          s_nxt.div = 16'h0000;
        end
      end
      Q_PAUSE:
      begin
        s_nxt.div = s_r.div + 16'h0001;
        if (s_r.div == 16'(RST_WAIT - 1))
        begin
          s_nxt.q = Q_ID;
          s_nxt.have_prev = 1'b0;
        end
      end
      Q_ID:
      begin
        go = 1'b1;
        if (done)
        begin
          s_nxt.prev = rxv[7:0];
          s_nxt.have_prev = 1'b1;
          if (s_r.have_prev && rxv[7:0] == s_r.prev)
          begin
            s_nxt.q = Q_DEF;
            s_nxt.idx = 2'h0;
            s_nxt.ok = (rxv[7:0] == IDENT_VAL);
          end
        end
      end
      Q_DEF:
      begin
        go = 1'b1;
        gtx = rd_frame(a);
        gnb = frame_len(a);
        if (done)
        begin
          if ((reg_is16(a) ? rxv : {8'h00, rxv[7:0]}) != reg_default(a))
          begin
            s_nxt.ok = 1'b0;
          end
          s_nxt.idx = s_r.idx + 2'h1;
          if (s_r.idx == 2'h3)
          begin
            s_nxt.q = Q_WCFG;
          end
        end
      end
      Q_WCFG:
      begin
        go = 1'b1;
        gtx = {cmd_byte(1'b0, A_CONFIG), s_r.wdata[7:0], 16'h0000};
        if (done)
        begin
          s_nxt.q = Q_TEMP;
        end
      end
      Q_TEMP:
      begin
        go = 1'b1;
        gtx = rd_frame(A_TEMP);
        gnb = 6'd24;
        if (done)
        begin
          s_nxt.q = Q_IDLE;
          s_nxt.rdata = rxv;
          s_nxt.link_ok = s_r.ok;
          s_nxt.link_fail = ~s_r.ok;
          iset[IRQ_PASS] = s_r.ok;
          iset[IRQ_FAIL] = ~s_r.ok;
        end
      end
      Q_ONE:
      begin
        go = 1'b1;
        gtx = {cmd_byte(s_r.rd, s_r.addr), s_r.wdata, 8'h00};
        if (!reg_is16(s_r.addr))
        begin
          gtx[23:16] = s_r.wdata[7:0];
        end
        gnb = frame_len(s_r.addr);
        if (done)
        begin
          s_nxt.q = Q_IDLE;
          s_nxt.rdata = reg_is16(s_r.addr) ? rxv : {8'h00, rxv[7:0]};
          iset[IRQ_DONE] = 1'b1;
        end
      end
      default: s_nxt.q = Q_IDLE;
    endcase

    // serial engine; sclk low phase sets mosi, data sampled late in high phase
    case (s_r.e)
      E_IDLE:
      begin
        if (go && !s_r.pend)
        begin
          s_nxt.pend = 1'b1;
          s_nxt.e = E_LO;
          s_nxt.tx = gtx;
          s_nxt.nb = gnb;
          s_nxt.bitn = 6'h00;
          s_nxt.div = 16'h0000;
          s_nxt.csn = 1'b0;
          s_nxt.sclk = 1'b0;
          s_nxt.mosi = gtx[31];
        end
      end
      E_LO:
      begin
        s_nxt.div = s_r.div + 16'h0001;
        if (s_r.div == 16'(SCLK_HALF - 1))
        begin
          s_nxt.div = 16'h0000;
          s_nxt.sclk = 1'b1;
          s_nxt.e = E_HI;
        end
      end
      E_HI:
      begin
        s_nxt.div = s_r.div + 16'h0001;
        if (s_r.div == 16'(SCLK_HALF - 1))
        begin
          s_nxt.div = 16'h0000;
          s_nxt.rx = {s_r.rx[14:0], s_r.miso_s};
          s_nxt.bitn = s_r.bitn + 6'h01;
          if (s_r.bitn == s_r.nb - 6'h01)
          begin
            s_nxt.e = E_GAP;
            s_nxt.csn = 1'b1;
          end
          else
          begin
            s_nxt.e = E_LO;
            s_nxt.sclk = 1'b0;
            s_nxt.mosi = s_r.tx[30];
            s_nxt.tx = {s_r.tx[30:0], 1'b0};
          end
        end
      end
      default:
      begin
        s_nxt.div = s_r.div + 16'h0001;
        s_nxt.mosi = 1'b0;
        if (done)
        begin
          s_nxt.e = E_IDLE;
          s_nxt.pend = 1'b0;
          s_nxt.div = 16'h0000;
        end
      end
    endcase

    // apb slave, one wait state on every access
    acc = psel && penable && !s_r.pready;
    s_nxt.pready = acc;
    s_nxt.pslverr = 1'b0;
    if (acc)
    begin
      s_nxt.prdata = 32'h00000000;
      case (paddr)
        H_CMD:
        begin
          if (pwrite && s_r.q == Q_IDLE)
          begin
            s_nxt.addr = pwdata[2:0];
            s_nxt.rd = pwdata[HC_RD_BIT];
            s_nxt.q = pwdata[HC_BRINGUP_BIT] ? Q_RST : Q_ONE;
            s_nxt.link_ok = pwdata[HC_BRINGUP_BIT] ? 1'b0 : s_r.link_ok;
            s_nxt.link_fail = pwdata[HC_BRINGUP_BIT] ? 1'b0 : s_r.link_fail;
          end
          s_nxt.prdata = {26'h0, s_r.rd, s_r.q == Q_RST, s_r.rd, s_r.addr};
        end
        H_WDATA:
        begin
          if (pwrite)
          begin
            s_nxt.wdata = pwdata[15:0];
          end
          s_nxt.prdata = {16'h0000, s_r.wdata};
        end
        H_RDATA: s_nxt.prdata = {16'h0000, s_r.rdata};
        H_STATUS: s_nxt.prdata = {29'h0, s_r.link_fail, s_r.link_ok, s_r.q != Q_IDLE};
        H_IRQ_STAT:
        begin
          if (pwrite)
          begin
            s_nxt.ist = s_r.ist & ~pwdata[2:0];
          end
          s_nxt.prdata = {29'h0, s_r.ist};
        end
        H_IRQ_MASK:
        begin
          if (pwrite)
          begin
            s_nxt.imask = pwdata[2:0];
          end
          s_nxt.prdata = {29'h0, s_r.imask};
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // new event wins over a clear in the same cycle
    s_nxt.ist = s_nxt.ist | iset;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_r <= '0;
      s_r.q <= Q_IDLE;
      s_r.e <= E_IDLE;
      s_r.sclk <= 1'b1;
      s_r.csn <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign link.sclk = s_r.sclk;
  assign link.cs_n = s_r.csn;
  assign link.mosi = s_r.mosi;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq_o = s_r.irq;

endmodule

/* verilog/tal_link_if.sv */
// Purpose: four-wire serial link between host and sensor
// Assumes: host drives sclk, cs_n and mosi; sensor drives miso
// Notes: sclk idles high
`timescale 1ns/1ps
interface tal_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

/* verilog/tal_pkg.sv */
// Purpose: shared constants for the temperature-alert sensor link
// Assumes: 20 MHz mclk on both ends
// Notes: register map, field positions, defaults and timing counts
package tal_pkg;
  localparam int MCLK_KHZ = 20000;
  localparam int RST_WAIT_US = 500;
  localparam int RST_WAIT_CYC = (RST_WAIT_US * MCLK_KHZ + 999) / 1000;
  localparam int SCLK_HALF_CYC = 4;
  localparam int ONES_RST = 32;
  localparam logic [2:0] A_STATUS = 3'h0;
  localparam logic [2:0] A_CONFIG = 3'h1;
  localparam logic [2:0] A_TEMP = 3'h2;
  localparam logic [2:0] A_IDENT = 3'h3;
  localparam logic [2:0] A_CRIT = 3'h4;
  localparam logic [2:0] A_HYST = 3'h5;
  localparam logic [2:0] A_UPPER = 3'h6;
  localparam logic [2:0] A_LOWER = 3'h7;
  // identification value is arbitrary
  localparam logic [7:0] IDENT_VAL = 8'h5a;
  localparam logic [7:0] CONFIG_DEF = 8'h00;
  localparam logic [15:0] CRIT_DEF = 16'h4000;
  localparam logic [3:0] HYST_DEF = 4'h5;
  localparam logic [15:0] UPPER_DEF = 16'h2000;
  localparam logic [15:0] LOWER_DEF = 16'h0500;
  localparam int CFG_CMP_BIT = 4;
  localparam int CFG_SD_LSB = 5;
  localparam logic [1:0] CFG_SD_VAL = 2'h3;
  localparam int HYST_SHIFT = 7;
  localparam int CMD_RD_BIT = 6;
  localparam int CMD_ADDR_LSB = 3;
  // host apb map
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_RDATA = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0c;
  localparam logic [7:0] H_IRQ_STAT = 8'h10;
  localparam logic [7:0] H_IRQ_MASK = 8'h14;
  localparam int HC_RD_BIT = 3;
  localparam int HC_BRINGUP_BIT = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_PASS = 1;
  localparam int IRQ_FAIL = 2;

  function automatic logic reg_is16(input logic [2:0] a);
    return (a == A_TEMP) || (a == A_CRIT) || (a == A_UPPER) || (a == A_LOWER);
  endfunction

  function automatic logic [7:0] cmd_byte(input logic rd, input logic [2:0] a);
    return {1'b0, rd, a, 3'h0};
  endfunction

  function automatic logic [15:0] reg_default(input logic [2:0] a);
    case (a)
      A_CONFIG: return {8'h00, CONFIG_DEF};
      A_IDENT: return {8'h00, IDENT_VAL};
      A_CRIT: return CRIT_DEF;
      A_HYST: return {12'h000, HYST_DEF};
      A_UPPER: return UPPER_DEF;
      A_LOWER: return LOWER_DEF;
      default: return 16'h0000;
    endcase
  endfunction
endpackage
